// ===== verilog/flash_host_pkg.sv
package flash_host_pkg;

	// Command codes written to the device, and the value an erased byte reads back as
	localparam logic [7:0] CMD_READ       = 8'h00;
	localparam logic [7:0] CMD_IDENT      = 8'h90;
	localparam logic [7:0] CMD_ERASE      = 8'h20;
	localparam logic [7:0] CMD_ERASE_CHK  = 8'hA0;
	localparam logic [7:0] CMD_PROG       = 8'h40;
	localparam logic [7:0] CMD_PROG_CHK   = 8'hC0;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] ERASED_BYTE    = 8'hFF;

	// Identifier locations
	localparam logic [17:0] ID_MAKER_LOC  = 18'h00000;
	localparam logic [17:0] ID_PART_LOC   = 18'h00001;

	// Bus timing: each strobe phase lasts this long
	localparam int PHASE_NS     = 100;
	localparam int CLK_NS       = 20;
	localparam int PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
	// Program and erase pulse lengths
	localparam int PROG_US      = 10;
	localparam int ERASE_MS     = 10;
	localparam int PROG_CYC     = PROG_US * 1000 / CLK_NS;
	localparam int ERASE_CYC    = ERASE_MS * 1000000 / CLK_NS;
	localparam int CNT_W        = 20;

	typedef enum logic [2:0]
	{
		OP_READ  = 3'h0,
		OP_IDENT = 3'h1,
		OP_PROG  = 3'h2,
		OP_ERASE = 3'h3,
		OP_ABORT = 3'h4
	} op_t;

	typedef struct packed
	{
		op_t         op;
		logic [17:0] addr;
		logic [7:0]  data;
	} req_t;

	typedef struct packed
	{
		logic        ok;
		logic [17:0] addr;
		logic [7:0]  data;
	} rsp_t;

endpackage : flash_host_pkg

// ===== verilog/flash_host.sv
`timescale 1ns/1ps
module flash_host #(
	parameter int ADDR_W    = 18,
	parameter int LAST_ADDR = 262143,
	parameter int MAX_TRY   = 25,
	parameter int PROG_CYC  = flash_host_pkg::PROG_CYC,
	parameter int ERASE_CYC = flash_host_pkg::ERASE_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire flash_host_pkg::req_t  req,
	input  wire logic                  reqValid,
	output logic                       reqReady,
	output flash_host_pkg::rsp_t       rsp,
	output logic                       rspValid,
	input  wire logic                  supplyHigh,
	output logic                       chipSelN,
	output logic                       writeStrobeN,
	output logic                       readStrobeN,
	output logic [17:0]                addrOut,
	output logic [7:0]                 dataOut,
	output logic                       dataOe,
	input  wire logic [7:0]            dataIn
);
	initial
	begin
		if (ADDR_W != 18 || MAX_TRY < 1 || PROG_CYC < 1 || ERASE_CYC < 1
			|| ERASE_CYC >= (1 << flash_host_pkg::CNT_W))
			$error("flash_host: unsupported parameters");
	end

	typedef enum logic [9:0]
	{
		S_IDLE  = 10'h001,
		S_CMD1  = 10'h002,
		S_CMD2  = 10'h004,
		S_WAIT  = 10'h008,
		S_CHK   = 10'h010,
		S_READ  = 10'h020,
		S_READ2 = 10'h040,
		S_EXIT  = 10'h080,
		S_DONE  = 10'h100,
		S_FAIL  = 10'h200
	} state_t;

	////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic       supMeta_ff, sup_ff;
	logic [7:0] dinMeta_ff, din_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			supMeta_ff <= 1'b0;
			sup_ff     <= 1'b0;
			dinMeta_ff <= 8'h00;
			din_ff     <= 8'h00;
		end
		else
		begin
			supMeta_ff <= supplyHigh;
			sup_ff     <= supMeta_ff;
			dinMeta_ff <= dataIn;
			din_ff     <= dinMeta_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus cycle engine: one write or read of PHASE_CYC low + high
	logic        busGo, busWr, busDone;
	logic [7:0]  busData;
	logic [17:0] busAddr;
	logic [3:0]  phase_ff;
	logic        busy_ff, low_ff;
	logic [7:0]  rdByte_ff;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busy_ff      <= 1'b0;
			low_ff       <= 1'b0;
			phase_ff     <= 4'h0;
			chipSelN     <= 1'b1;
			writeStrobeN <= 1'b1;
			readStrobeN  <= 1'b1;
			addrOut      <= 18'h00000;
			dataOut      <= 8'h00;
			dataOe       <= 1'b1;
			rdByte_ff    <= 8'h00;
		end
		else if (busGo && !busy_ff)
		begin
			busy_ff      <= 1'b1;
			low_ff       <= 1'b1;
			phase_ff     <= 4'(flash_host_pkg::PHASE_CYC);
			chipSelN     <= 1'b0;
			writeStrobeN <= !busWr;
			readStrobeN  <= busWr;
			addrOut      <= busAddr;
			dataOut      <= busData;
			dataOe       <= !busWr;
		end
		else if (busy_ff)
		begin
			if (phase_ff != 4'h1)
				phase_ff <= phase_ff - 4'h1;
			else if (low_ff)
			begin
				// Take read data while the device still drives it
				rdByte_ff    <= din_ff;
				low_ff       <= 1'b0;
				phase_ff     <= 4'(flash_host_pkg::PHASE_CYC);
				writeStrobeN <= 1'b1;
				readStrobeN  <= 1'b1;
			end
			else
			begin
				busy_ff  <= 1'b0;
				chipSelN <= 1'b1;
				dataOe   <= 1'b1;
			end
		end
	end
	assign busDone = busy_ff && !low_ff && phase_ff == 4'h1;

	////////////////////////////////////////////////////////////////
	// Operation sequencer
	state_t            state_ff;
	flash_host_pkg::op_t op_ff;
	logic [17:0]       addr_ff;
	logic [7:0]        data_ff;
	logic [7:0]        try_ff;
	logic [2:0]        step_ff;
	logic [flash_host_pkg::CNT_W-1:0] wait_ff;
	logic              sentGo_ff;

	always_comb
	begin
		busGo   = 1'b0;
		busWr   = 1'b1;
		busAddr = addr_ff;
		busData = flash_host_pkg::CMD_READ;
		case (state_ff)
			S_CMD1:
			begin
				busGo = !sentGo_ff;
				case (op_ff)
					flash_host_pkg::OP_IDENT: busData = flash_host_pkg::CMD_IDENT;
					flash_host_pkg::OP_PROG:  busData = flash_host_pkg::CMD_PROG;
					flash_host_pkg::OP_ERASE: busData = flash_host_pkg::CMD_ERASE;
					flash_host_pkg::OP_ABORT: busData = flash_host_pkg::CMD_RESET;
					default:                  busData = flash_host_pkg::CMD_READ;
				endcase
			end
			S_CMD2:
			begin
				busGo   = !sentGo_ff;
				busData = (op_ff == flash_host_pkg::OP_PROG) ? data_ff
					: (op_ff == flash_host_pkg::OP_ERASE)
					? flash_host_pkg::CMD_ERASE
					: flash_host_pkg::CMD_RESET;
			end
			S_CHK:
			begin
				busGo   = !sentGo_ff;
				busData = (op_ff == flash_host_pkg::OP_PROG)
					? flash_host_pkg::CMD_PROG_CHK
					: flash_host_pkg::CMD_ERASE_CHK;
			end
			S_READ:
			begin
				busGo   = !sentGo_ff;
				busWr   = 1'b0;
				busAddr = (op_ff == flash_host_pkg::OP_IDENT)
					? flash_host_pkg::ID_MAKER_LOC : addr_ff;
			end
			S_READ2:
			begin
				busGo   = !sentGo_ff;
				busWr   = 1'b0;
				busAddr = flash_host_pkg::ID_PART_LOC;
			end
			S_EXIT:
			begin
				busGo   = !sentGo_ff;
				busData = flash_host_pkg::CMD_READ;
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff  <= S_IDLE;
			op_ff     <= flash_host_pkg::OP_READ;
			addr_ff   <= 18'h00000;
			data_ff   <= 8'h00;
			try_ff    <= 8'h00;
			step_ff   <= 3'h0;
			wait_ff   <= '0;
			sentGo_ff <= 1'b0;
			reqReady  <= 1'b0;
			rspValid  <= 1'b0;
			rsp       <= '0;
		end
		else
		begin
			rspValid <= 1'b0;
			if (busGo && !busy_ff)
				sentGo_ff <= 1'b1;
			if (busDone)
				sentGo_ff <= 1'b0;
			case (state_ff)
				S_IDLE:
				begin
					reqReady <= sup_ff && !busy_ff;
					if (reqValid && reqReady && sup_ff)
					begin
						reqReady <= 1'b0;
						op_ff    <= req.op;
						addr_ff  <= req.addr;
						data_ff  <= req.data;
						try_ff   <= 8'h00;
						state_ff <= S_CMD1;
					end
				end
				S_CMD1:
					if (busDone)
						state_ff <= (op_ff == flash_host_pkg::OP_READ)
							? S_READ
							: (op_ff == flash_host_pkg::OP_IDENT) ? S_READ : S_CMD2;
				S_CMD2:
					if (busDone)
					begin
						if (op_ff == flash_host_pkg::OP_ABORT)
							state_ff <= S_EXIT;
						else
						begin
							try_ff   <= try_ff + 8'h01;
							wait_ff  <= (op_ff == flash_host_pkg::OP_PROG)
								? flash_host_pkg::CNT_W'(PROG_CYC)
								: flash_host_pkg::CNT_W'(ERASE_CYC);
							state_ff <= S_WAIT;
						end
					end
				S_WAIT:
					if (wait_ff <= 1)
						state_ff <= S_CHK;
					else
						wait_ff <= wait_ff - 1'b1;
				S_CHK:
					if (busDone)
						state_ff <= S_READ;
				S_READ:
					if (busDone)
					begin
						rsp.data <= rdByte_ff;
						rsp.addr <= addr_ff;
						if (op_ff == flash_host_pkg::OP_IDENT)
							state_ff <= S_READ2;
						else if (op_ff == flash_host_pkg::OP_READ)
						begin
							rsp.ok   <= 1'b1;
							state_ff <= S_DONE;
						end
						else if (op_ff == flash_host_pkg::OP_PROG)
						begin
							if (rdByte_ff == data_ff)
								state_ff <= S_EXIT;
							else if (try_ff >= 8'(MAX_TRY))
								state_ff <= S_FAIL;
							else
								state_ff <= S_CMD1;
						end
						else if (rdByte_ff == flash_host_pkg::ERASED_BYTE)
						begin
							if (addr_ff == 18'(LAST_ADDR))
								state_ff <= S_EXIT;
							else
							begin
								addr_ff  <= addr_ff + 18'h00001;
								state_ff <= S_CHK;
							end
						end
						else if (try_ff >= 8'(MAX_TRY))
							state_ff <= S_FAIL;
						else
							state_ff <= S_CMD1;
					end
				S_READ2:
					if (busDone)
					begin
						rsp.addr <= {rsp.data, rdByte_ff, 2'b00};
						state_ff <= S_EXIT;
					end
				S_EXIT:
					if (busDone)
					begin
						rsp.ok   <= 1'b1;
						state_ff <= S_DONE;
					end
				S_FAIL:
				begin
					rsp.ok   <= 1'b0;
					state_ff <= S_DONE;
				end
				S_DONE:
				begin
					rspValid <= 1'b1;
					state_ff <= S_IDLE;
				end
				default: state_ff <= S_IDLE;
			endcase
			if (!sup_ff && state_ff != S_IDLE && state_ff != S_DONE)
			begin
				rsp.ok   <= 1'b0;
				state_ff <= S_DONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	strobe_pair_a: assert property (@(posedge clk) disable iff (rst)
		!writeStrobeN |-> !chipSelN)
		else $error("write strobe without chip select");
	no_write_low_a: assert property (@(posedge clk) disable iff (rst)
		$fell(writeStrobeN) |-> $past(sup_ff))
		else $error("write started with supply low");
	verify_ends_a: assert property (@(posedge clk) disable iff (rst)
		state_ff == S_WAIT && wait_ff <= 1 && sup_ff |=> state_ff == S_CHK)
		else $error("pulse not ended by verify");
	chk_code_a: assert property (@(posedge clk) disable iff (rst)
		state_ff == S_CHK && !writeStrobeN |-> dataOut ==
			((op_ff == flash_host_pkg::OP_PROG) ? flash_host_pkg::CMD_PROG_CHK
			: flash_host_pkg::CMD_ERASE_CHK))
		else $error("bad verify code");
	read_nowrite_a: assert property (@(posedge clk) disable iff (rst)
		!readStrobeN |-> writeStrobeN && dataOe)
		else $error("read overlaps write");
	done_pulse_a: assert property (@(posedge clk) disable iff (rst)
		rspValid |=> !rspValid)
		else $error("response longer than one cycle");
	abort_exit_a: assert property (@(posedge clk) disable iff (rst)
		state_ff == S_CMD2 && op_ff == flash_host_pkg::OP_ABORT && busDone
		&& sup_ff |=> state_ff == S_EXIT)
		else $error("abort without closing command");
	low_supply_a: assert property (@(posedge clk) disable iff (rst)
		!sup_ff |-> ##1 !reqReady)
		else $error("ready with supply low");
	prog_cov: cover property (@(posedge clk) disable iff (rst)
		rspValid && rsp.ok && op_ff == flash_host_pkg::OP_PROG);
	erase_cov: cover property (@(posedge clk) disable iff (rst)
		rspValid && rsp.ok && op_ff == flash_host_pkg::OP_ERASE);
	ident_cov: cover property (@(posedge clk) disable iff (rst)
		rspValid && op_ff == flash_host_pkg::OP_IDENT);

endmodule : flash_host

// ===== verification/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART  = 8'h3C  // Arbitrary value
) (
	input  wire logic        supplyHigh,
	input  wire logic        chipSelN,
	input  wire logic        writeStrobeN,
	input  wire logic        readStrobeN,
	input  wire logic [17:0] addr,
	input  wire logic [7:0]  wrData,
	output logic [7:0]       rdData
);
	logic [7:0]  mem [16];
	logic [7:0]  wrLatch;
	logic [17:0] wrAddr;
	logic [3:0]  progLoc;
	logic [3:0]  chkLoc;
	logic [7:0]  progByte;
	logic        selLatch;
	logic [7:0]  sense;
	int          mode;
	// Modes: 0 read, 1 ident, 2/3 erase armed/running, 4 erase check,
	// 5/6 program armed/running, 7 program check, 8 half reset
	initial
	begin
		mode = 0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(negedge supplyHigh) mode = 0;
	always @(negedge writeStrobeN)
	begin
		// Let the host's same-edge pin updates settle
		#1;
		selLatch = !chipSelN;
		wrAddr = addr;
	end
	always @(wrData or writeStrobeN) if (!writeStrobeN) wrLatch = wrData;
	always @(posedge writeStrobeN)
		if (selLatch && supplyHigh)
		begin
			if (mode == 3) foreach (mem[i]) mem[i] = 8'hFF;
			if (mode == 6) mem[progLoc] = mem[progLoc] & progByte;
			if (mode == 5)
			begin
				progLoc = wrAddr[3:0];
				progByte = wrLatch;
				mode = 6;
			end
			else
				case (wrLatch)
				8'h00: mode = 0;
				8'h90: mode = 1;
				8'h20: mode = (mode == 2) ? 3 : 2;
				8'hA0:
				begin
					chkLoc = wrAddr[3:0];
					mode = 4;
				end
				8'h40: mode = 5;
				8'hC0: mode = 7;
				8'hFF: mode = (mode == 8) ? 0 : 8;
				default: mode = 0;
				endcase
		end
	always_comb
		case (mode)
		1: sense = addr[0] ? PART : MAKER;
		4: sense = mem[chkLoc];
		7: sense = mem[progLoc];
		default: sense = mem[addr[3:0]];
		endcase
	// Released bus shows the inverse so stale values are never trusted
	assign rdData = (!chipSelN && !readStrobeN) ? sense : ~sense;
endmodule : flash_dev_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int         LAST  = 15;
	localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
	localparam logic [7:0] PART  = 8'h3C; // Arbitrary value
	logic                  clk, rst, reqValid, reqReady, rspValid;
	logic                  supplyHigh, chipSelN, writeStrobeN;
	logic                  readStrobeN, dataOe;
	logic [17:0]           addrOut;
	logic [7:0]            dataOut, dataIn, d;
	flash_host_pkg::req_t  req;
	flash_host_pkg::rsp_t  rsp, r;
	int                    badCount, testsRun, a, refMem [16];
	flash_host #(.LAST_ADDR(LAST), .PROG_CYC(4), .ERASE_CYC(10)) uut (
		.clk(clk), .rst(rst), .req(req), .reqValid(reqValid),
		.reqReady(reqReady), .rsp(rsp), .rspValid(rspValid),
		.supplyHigh(supplyHigh), .chipSelN(chipSelN),
		.writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
		.addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe),
		.dataIn(dataIn));
	flash_dev_model #(.MAKER(MAKER), .PART(PART)) dev (
		.supplyHigh(supplyHigh), .chipSelN(chipSelN),
		.writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
		.addr(addrOut), .wrData(dataOut), .rdData(dataIn));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic finishTest;
		$display("Checks %0d, mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finishTest
	task automatic check(input string n, input logic [31:0] e, g);
		testsRun++;
		if (g !== e)
		begin
			badCount++;
			$display("BAD %s expected %0h seen %0h", n, e, g);
		end
	endtask : check
	task automatic hang(input string n);
		badCount++;
		$display("BAD %s expected done seen timeout", n);
		finishTest();
	endtask : hang
	task automatic doReq(input flash_host_pkg::op_t op, input int ad,
		input logic [7:0] dt);
		int n;
		req <= '{op, ad[17:0], dt};
		reqValid <= 1'b1;
		n = 0;
		@(posedge clk);
		while (reqReady !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		reqValid <= 1'b0;
		if (n >= 200) hang("reqReady");
		n = 0;
		while (rspValid !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) hang("rspValid");
		r = rsp;
	endtask : doReq
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(8312));
		rst = 1'b1;
		reqValid = 1'b0;
		req = '0;
		supplyHigh = 1'b0;
		badCount = 0;
		testsRun = 0;
		foreach (refMem[i]) refMem[i] = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		check("ready with supply low", 0, reqReady);
		supplyHigh <= 1'b1;
		doReq(flash_host_pkg::OP_IDENT, 0, 8'h00);
		check("ident codes", {MAKER, PART, 2'b00}, r.addr);
		doReq(flash_host_pkg::OP_READ, 3, 8'h00);
		check("read after ident", refMem[3], r.data);
		doReq(flash_host_pkg::OP_ERASE, 0, 8'h00);
		foreach (refMem[i]) refMem[i] = 8'hFF;
		check("erase ok", 1, r.ok);
		check("erase last", LAST, r.addr);
		fork
			doReq(flash_host_pkg::OP_PROG, 5, 8'h00);
			begin
				repeat (12) @(posedge clk);
				supplyHigh <= 1'b0;
			end
		join
		check("prog supply drop", 0, r.ok);
		supplyHigh <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			a = $urandom_range(LAST);
			d = $urandom;
			doReq(flash_host_pkg::OP_PROG, a, d);
			check("prog ok", (refMem[a] & d) == d, r.ok);
			refMem[a] &= d;
			check("prog readback", refMem[a], r.data);
		end
		doReq(flash_host_pkg::OP_ABORT, 0, 8'h00);
		for (int k = 0; k <= LAST; k++)
		begin
			doReq(flash_host_pkg::OP_READ, k, 8'h00);
			check("array byte", refMem[k], r.data);
		end
		finishTest();
	end
endmodule : testbench
